// ---- design/srbw_pkg.sv ----
// package: constants, register map and carrier types of the ring buffer writer
// Summary of operation
// [R1] single policy halts at last buffer location
// [R2] head and tail wrap to first location
// [R3] circular: head meeting tail means full, stop
// [R4] circular overflow halts and flags error
// [R5] recycled: keep writing over oldest scans
// [R6] recycled: writer advances tail by frames
// [R7] recycled never signals overflow
// [R8] each sample takes two consecutive bytes
// [R9] samples written in converter order
// [R10] samples left-justified, low bits zero
// [R11] consumer flips top bit to get signed
// [R12] consumer step weight is span over 65535
// [R13] consumer adds range offset after weighting
// [R14] consumer divides by channel gain
// [R15] three independent input setup bits
// [R16] scan list holds at most 256 entries
// [R17] scan starts by software or pacing pulse
// [R18] single scan keeps samples in fifo
// [R19] controller rewrites whole setup word
// [R20] enable, start trigger, then software scan
// [R21] controller waits one period per entry
// [R22] frame boundary crossing raises event
// [R23] start clears head, tail and overflow
// [R24] two-bit policy sampled at start
package srbw_pkg;
  // register byte offsets
  localparam logic [4:0] REG_CTRL   = 5'h00; // go, stop, scan pulse, single
  localparam logic [4:0] REG_SETUP  = 5'h04; // input_setup_word
  localparam logic [4:0] REG_GEOM   = 5'h08; // buffer words, frame words
  localparam logic [4:0] REG_TAIL   = 5'h0c; // consumer tail (write)
  localparam logic [4:0] REG_STATUS = 5'h10; // state and flags
  localparam logic [4:0] REG_HEAD   = 5'h14; // head and frame count
  // ctrl fields
  localparam int CTRL_GO     = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_SCAN   = 2;
  localparam int CTRL_SINGLE = 3;
  // setup word fields
  localparam int SET_DIFF    = 0;
  localparam int SET_BIPOLAR = 1;
  localparam int SET_TENV    = 2;
  localparam int SET_CVA     = 3;
  localparam int SET_CVB     = 4;
  localparam int SET_EXTPACE = 5;
  localparam int SET_POL_LO  = 6;
  localparam int SET_RES_LO  = 8;
  localparam int SET_LEN_LO  = 16;
  localparam logic [31:0] SETUP_RST = 32'h0000_0000;
  // sizes
  localparam int  AW        = 16;           // host word index width
  localparam int  SCAN_MAX  = 256;
  localparam logic [8:0] SCAN_MAX_W = 9'h100;
  localparam logic [15:0] GEOM_BUF_RST = 16'h0100;
  localparam logic [15:0] GEOM_FRM_RST = 16'h0040;
  // policy and resolution codes
  typedef enum logic [1:0] {
    SRBW_POL_SINGLE   = 2'b00,
    SRBW_POL_CIRCULAR = 2'b01,
    SRBW_POL_RECYCLED = 2'b10
  } srbw_pol_t;
  localparam logic [1:0] RES_16 = 2'b00;
  localparam logic [1:0] RES_14 = 2'b01;
  localparam logic [1:0] RES_12 = 2'b10;
  typedef enum logic [1:0] {
    SRBW_IDLE = 2'b00,
    SRBW_RUN  = 2'b01,
    SRBW_DONE = 2'b10,
    SRBW_ERR  = 2'b11
  } srbw_state_t;
  // host memory write carrier
  typedef struct packed {
    logic          valid;
    logic [AW:0]   byte_addr; // even byte address
    logic [15:0]   data;
  } srbw_wr_t;
  // converter sample carrier
  typedef struct packed {
    logic          valid;
    logic [15:0]   raw;      // right-justified code
  } srbw_smp_t;
endpackage : srbw_pkg

// ---- design/srbw_writer.sv ----
// module: ring buffer writer with avalon register slave
module srbw_writer
  import srbw_pkg::*;
(
  input  wire logic        ref_clk_in,         // 50 mhz clock
  input  wire logic        rstn_in,            // async reset, active low
  input  wire logic [4:0]  avs_address_in,     // byte address
  input  wire logic        avs_read_in,        // read request
  input  wire logic        avs_write_in,       // write request
  input  wire logic [31:0] avs_writedata_in,   // write data
  input  wire logic [3:0]  avs_byteenable_in,  // byte lanes
  output logic [31:0]      avs_readdata_out,   // read data
  output logic             avs_waitrequest_out,// stall
  input  wire srbw_smp_t   smp_in,             // converter sample
  input  wire logic        scan_pacing_pulse_in, // external scan pulse
  output srbw_wr_t         host_wr_out,        // host memory write
  output logic             scan_start_out,     // start a scan
  output logic             conv_enable_out,    // conversions enabled
  output logic             frame_event_out,    // frame boundary pulse
  output logic             overflow_out,       // buffer error flag
  output logic             fifo_keep_out       // hold samples on board
);
  // reset release through two flops
  logic rst_meta_reg, rst_sync_reg;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rstn = rst_sync_reg;

  // registers
  logic [31:0]   setup_reg;
  logic [15:0]   buf_words_reg, frame_words_reg;
  logic [AW-1:0] head_reg, tail_reg, frame_pos_reg;
  logic [15:0]   frame_cnt_reg;
  logic          single_reg, ovf_reg, frame_reg, ack_reg;
  logic [8:0]    scan_idx_reg;
  srbw_pol_t     pol_reg;
  srbw_state_t   state_reg;
  srbw_wr_t      wr_reg;

  // bus decode; one wait cycle so read data come from a flop
  wire acc      = avs_read_in | avs_write_in;
  wire wr_en    = avs_write_in & ack_reg & (&avs_byteenable_in);
  wire wr_ctrl  = wr_en & (avs_address_in == REG_CTRL);
  wire wr_setup = wr_en & (avs_address_in == REG_SETUP);
  wire wr_geom  = wr_en & (avs_address_in == REG_GEOM);
  wire wr_tail  = wr_en & (avs_address_in == REG_TAIL);
  wire go       = wr_ctrl & avs_writedata_in[CTRL_GO];
  wire stop     = wr_ctrl & avs_writedata_in[CTRL_STOP];
  wire sw_scan  = wr_ctrl & avs_writedata_in[CTRL_SCAN];
  assign avs_waitrequest_out = acc & ~ack_reg;

  // setup word decode
  wire       ext_pace = setup_reg[SET_EXTPACE];
  wire [1:0] res      = setup_reg[SET_RES_LO +: 2];
  wire [8:0] len_raw  = setup_reg[SET_LEN_LO +: 9];
  wire [8:0] scan_len = (len_raw > SCAN_MAX_W) ? SCAN_MAX_W : len_raw; // R16
  wire       conv_en  = setup_reg[SET_CVA] & setup_reg[SET_CVB];
  wire       running  = (state_reg == SRBW_RUN);

  // left justification of the converter code
  wire [15:0] just = (res == RES_14) ? {smp_in.raw[13:0], 2'b00} :   // R10
                     (res == RES_12) ? {smp_in.raw[11:0], 4'b0000} : // R10
                     smp_in.raw;
  // head advance and wrap
  wire [AW-1:0] last     = AW'(buf_words_reg - 16'h0001);
  wire          at_last  = (head_reg == last);
  wire [AW-1:0] head_nxt = at_last ? '0 : AW'(head_reg + 1'b1);      // R2
  wire          take     = running & smp_in.valid & ~single_reg;     // R18
  wire          hit_tail = (head_nxt == tail_reg);
  wire          frm_end  = (frame_pos_reg == AW'(frame_words_reg - 16'h1));
  // one spare bit keeps the carry, so large frames still wrap correctly
  wire [AW:0]   tail_frm = {1'b0, tail_reg} + {1'b0, frame_words_reg};
  wire [AW-1:0] tail_adv = (tail_frm >= {1'b0, buf_words_reg}) ?
                           AW'(tail_frm - {1'b0, buf_words_reg}) :
                           AW'(tail_frm); // R2
  wire halt_single = take & (pol_reg == SRBW_POL_SINGLE) & at_last;  // R1
  wire halt_full   = take & (pol_reg == SRBW_POL_CIRCULAR) & hit_tail; // R3
  wire recycle     = take & (pol_reg == SRBW_POL_RECYCLED) & hit_tail; // R5

  // configuration registers
  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      setup_reg       <= SETUP_RST;
      buf_words_reg   <= GEOM_BUF_RST;
      frame_words_reg <= GEOM_FRM_RST;
      single_reg      <= 1'b0;
      ack_reg         <= 1'b0;
    end
    else
    begin
      ack_reg <= acc & ~ack_reg;
      if (wr_setup)
        setup_reg <= avs_writedata_in; // whole word replaced, R15 R19
      if (wr_geom)
      begin
        buf_words_reg   <= avs_writedata_in[15:0];
        frame_words_reg <= avs_writedata_in[31:16];
      end
      if (wr_ctrl)
        single_reg <= avs_writedata_in[CTRL_SINGLE];
    end
  end

  // acquisition state machine
  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= SRBW_IDLE;
      pol_reg   <= SRBW_POL_SINGLE;
      ovf_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        SRBW_IDLE, SRBW_DONE, SRBW_ERR:
          if (go)
          begin
            state_reg <= SRBW_RUN;
            pol_reg   <= srbw_pol_t'(setup_reg[SET_POL_LO +: 2]); // R24
            ovf_reg   <= 1'b0; // R23
          end
        SRBW_RUN:
          if (stop)
            state_reg <= SRBW_DONE;
          else if (halt_single)
            state_reg <= SRBW_DONE; // R1
          else if (halt_full)
          begin
            state_reg <= SRBW_ERR; // R3 R4
            ovf_reg   <= 1'b1;     // R4
          end
        default:
          state_reg <= SRBW_IDLE;
      endcase
    end
  end

  // head, tail and frame tracking
  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      head_reg      <= '0;
      tail_reg      <= '0;
      frame_pos_reg <= '0;
      frame_cnt_reg <= 16'h0000;
      frame_reg     <= 1'b0;
    end
    else if (go & ~running)
    begin
      head_reg      <= '0; // R23
      tail_reg      <= '0; // R23
      frame_pos_reg <= '0;
      frame_cnt_reg <= 16'h0000;
      frame_reg     <= 1'b0;
    end
    else
    begin
      frame_reg <= take & ~halt_full & frm_end; // R22
      if (take & ~halt_full)
      begin
        head_reg      <= head_nxt;
        frame_pos_reg <= frm_end ? '0 : AW'(frame_pos_reg + 1'b1);
        if (frm_end)
          frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
      if (recycle)
        tail_reg <= tail_adv; // R6
      else if (wr_tail)
        tail_reg <= avs_writedata_in[AW-1:0]; // R2
    end
  end

  // host word write, one 16-bit word per sample, in arrival order
  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
      wr_reg <= '0;
    else
    begin
      wr_reg.valid     <= take & ~halt_full;  // R9
      wr_reg.byte_addr <= {head_reg, 1'b0};   // R8
      wr_reg.data      <= just;               // R10
    end
  end

  // scan start from software or pacing pulse, position in the list
  wire scan_go = conv_en & (ext_pace ? scan_pacing_pulse_in : sw_scan); // R17
  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
      scan_idx_reg <= 9'h000;
    else if (scan_go)
      scan_idx_reg <= 9'h000;
    else if (smp_in.valid & (scan_idx_reg < scan_len))
      scan_idx_reg <= scan_idx_reg + 9'h001; // R16
  end

  // register read mux
  logic [31:0] rd_mux;
  assign rd_mux =
    (avs_address_in == REG_CTRL)   ? {28'h0, single_reg, 3'b000} :
    (avs_address_in == REG_SETUP)  ? setup_reg :
    (avs_address_in == REG_GEOM)   ? {frame_words_reg, buf_words_reg} :
    (avs_address_in == REG_TAIL)   ? {16'h0000, tail_reg} :
    (avs_address_in == REG_STATUS) ? {23'h0, scan_idx_reg[8:0] == 9'h0,
                                      3'b000, pol_reg, ovf_reg, state_reg} :
    (avs_address_in == REG_HEAD)   ? {frame_cnt_reg, head_reg} :
                                     32'h0000_0000;
  always_ff @(posedge ref_clk_in or negedge rstn)
  begin
    if (!rstn)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in & ~ack_reg)
      avs_readdata_out <= rd_mux;
  end

  assign host_wr_out     = wr_reg;
  assign scan_start_out  = scan_go;
  assign conv_enable_out = conv_en;
  assign frame_event_out = frame_reg;
  assign overflow_out    = ovf_reg;
  assign fifo_keep_out   = single_reg;

  // checks
  a_single_halt: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    halt_single & ~stop |=> state_reg == SRBW_DONE) // R1
    else $error("single policy did not halt at last location");
  a_head_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    take & at_last & ~halt_full & ~(go & ~running) |=> head_reg == '0) // R2
    else $error("head did not wrap");
  a_circ_full: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    halt_full & ~stop |=> state_reg == SRBW_ERR && ovf_reg) // R3
    else $error("circular full did not stop");
  a_ovf_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    ovf_reg & ~go |=> ovf_reg) // R4
    else $error("overflow flag lost");
  a_recycle_tail: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    recycle |=> tail_reg == $past(tail_adv)) // R6
    else $error("tail not advanced by a frame");
  a_recycle_noovf: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    running & pol_reg == SRBW_POL_RECYCLED |=> !$rose(ovf_reg)) // R7
    else $error("recycled policy raised overflow");
  a_word_addr: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    host_wr_out.valid
      |-> host_wr_out.byte_addr == {$past(head_reg), 1'b0}) // R8
    else $error("sample not on a two-byte boundary");
  a_just_low: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    host_wr_out.valid && $past(res) == RES_12
      |-> host_wr_out.data[3:0] == 4'h0) // R10
    else $error("12-bit sample not left justified");
  a_single_keep: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    single_reg |=> !host_wr_out.valid) // R18
    else $error("single scan forwarded to host");
  a_start_clear: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    go & ~running |=> head_reg == '0 && tail_reg == '0 && !ovf_reg) // R23
    else $error("start did not clear pointers");
endmodule : srbw_writer

// ---- sim/srbw_host_mem.sv ----
// host memory model: stores the words the writer sends, counts frame events
module srbw_host_mem
  import srbw_pkg::*;
(
  input  wire logic     clk_in,   // system clock
  input  wire srbw_wr_t wr_in,    // word write from the writer
  input  wire logic     frame_in  // frame boundary pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];       // host words, index is byte address / 2
  logic [AW:0] last_addr = '0;    // byte address of the newest word
  int          n_wr      = 0;     // words written so far
  int          n_frm     = 0;     // frame events seen so far
  // memory accepts a word at every valid; it never stalls the writer
  always @(posedge clk_in)
  begin
    if (wr_in.valid === 1'b1)
    begin
      mem[wr_in.byte_addr[8:1]] <= wr_in.data;
      last_addr <= wr_in.byte_addr;
      n_wr <= n_wr + 1;
    end
    if (frame_in === 1'b1)
      n_frm <= n_frm + 1;
  end
  // consumer view: flipping the top bit yields the signed code
  function automatic logic [15:0] to_code(input logic [15:0] w);
    return w ^ 16'h8000;
  endfunction : to_code
  // consumer scaling in millivolts: weight, then offset, then gain
  function automatic int to_mv(input logic [15:0] w, input int span_mv,
                               input int disp_mv, input int gain);
    int lvl;
    lvl = int'(to_code(w)) * span_mv / 65535;
    return (lvl + disp_mv) / gain;
  endfunction : to_mv
endmodule : srbw_host_mem

// ---- sim/sample_ring_buffer_writer_test.sv ----
// self-checking bench for the ring buffer writer
module sample_ring_buffer_writer_test;
  import srbw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic [4:0]  avs_address_in = '0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  srbw_smp_t   smp_in = '0;
  logic        scan_pacing_pulse_in = 1'b0;
  srbw_wr_t    host_wr_out;
  logic        scan_start_out;
  logic        conv_enable_out;
  logic        frame_event_out;
  logic        overflow_out;
  logic        fifo_keep_out;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n_start = 0;
  int          w0;
  int          f0;
  logic [31:0] q;

  srbw_writer srbw_writer_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .smp_in(smp_in),
    .scan_pacing_pulse_in(scan_pacing_pulse_in), .host_wr_out(host_wr_out),
    .scan_start_out(scan_start_out), .conv_enable_out(conv_enable_out),
    .frame_event_out(frame_event_out), .overflow_out(overflow_out),
    .fifo_keep_out(fifo_keep_out));
  srbw_host_mem srbw_host_mem_i (.clk_in(ref_clk_in), .wr_in(host_wr_out),
    .frame_in(frame_event_out));

  always #10 ref_clk_in = ~ref_clk_in;
  // scan starts are one-cycle pulses, so count them every cycle
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (scan_start_out === 1'b1)
      n_start <= n_start + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    // only the bench timeout ends a wait that never answers
    do
    begin
      @(posedge ref_clk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic push(input logic [15:0] raw);
    @(posedge ref_clk_in);
    smp_in <= '{valid: 1'b1, raw: raw};
    @(posedge ref_clk_in);
    smp_in <= '0;
    repeat (2) @(posedge ref_clk_in);
  endtask : push
  // stop, configure an 8-word buffer of 4-word frames, then go
  task automatic start(input logic [1:0] pol, input logic [1:0] res);
    bus(1'b1, REG_CTRL, 32'h2);
    bus(1'b1, REG_SETUP, 32'h0001_0018 | {22'h0, res, pol, 6'h0});
    bus(1'b1, REG_GEOM, 32'h0004_0008);
    bus(1'b1, REG_CTRL, 32'h1);
    @(posedge ref_clk_in); // let the go settle before anything is looked at
    w0 = srbw_host_mem_i.n_wr;
    f0 = srbw_host_mem_i.n_frm;
  endtask : start

  task automatic t_regs;
    bus(1'b0, REG_GEOM, '0);
    chk("geom", {GEOM_FRM_RST, GEOM_BUF_RST}, q);
    bus(1'b0, 5'h18, '0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, REG_SETUP, 32'h0000_0027);
    bus(1'b0, REG_SETUP, '0);
    chk("setup", 32'h0000_0027, q);
    chk("conv off", 32'h0, {31'h0, conv_enable_out});
    // a partial byte-lane write must leave the word untouched
    avs_byteenable_in <= 4'h3;
    bus(1'b1, REG_SETUP, 32'h0000_0018);
    avs_byteenable_in <= 4'hf;
    bus(1'b0, REG_SETUP, '0);
    chk("partial write", 32'h0000_0027, q);
  endtask : t_regs
  task automatic t_single;
    int v;
    start(SRBW_POL_SINGLE, RES_16);
    for (int i = 0; i < 9; i++)
      push(16'h1000 + 16'(i) * 16'h0111);
    chk("single words", 32'd8, 32'(srbw_host_mem_i.n_wr - w0));
    chk("frames", 32'd2, 32'(srbw_host_mem_i.n_frm - f0));
    chk("word 5", 32'h1555, 32'(srbw_host_mem_i.mem[5]));
    v = srbw_host_mem_i.to_mv(srbw_host_mem_i.mem[5], 5000, 0, 1);
    chk("volts uni", 32'd2916, 32'(v));
    v = srbw_host_mem_i.to_mv(srbw_host_mem_i.mem[5], 20000, -10000, 2);
    chk("volts bip", 32'd833, 32'(v));
    chk("last addr", 32'he, 32'(srbw_host_mem_i.last_addr));
    bus(1'b0, REG_STATUS, '0);
    chk("single state", 32'h2, {30'h0, q[1:0]});
  endtask : t_single
  task automatic t_res;
    start(SRBW_POL_SINGLE, RES_14);
    push(16'h2aab);
    chk("res14", 32'haaac, 32'(srbw_host_mem_i.mem[0]));
    start(SRBW_POL_SINGLE, RES_12);
    push(16'h09a5);
    chk("res12", 32'h9a50, 32'(srbw_host_mem_i.mem[0]));
  endtask : t_res
  task automatic t_circ;
    start(SRBW_POL_CIRCULAR, RES_16);
    repeat (4) push(16'h00aa);
    bus(1'b1, REG_TAIL, 32'h4);
    repeat (6) push(16'h00aa);
    chk("circ wrap", 32'h2, 32'(srbw_host_mem_i.last_addr));
    bus(1'b0, REG_STATUS, '0);
    chk("circ run", 32'h1, {30'h0, q[1:0]});
    repeat (2) push(16'h00aa);
    chk("circ words", 32'd11, 32'(srbw_host_mem_i.n_wr - w0));
    chk("overflow", 32'h1, {31'h0, overflow_out});
    bus(1'b0, REG_STATUS, '0);
    chk("circ state", 32'h3, {30'h0, q[1:0]});
  endtask : t_circ
  task automatic t_recyc;
    start(SRBW_POL_RECYCLED, RES_16);
    chk("go clears", 32'h0, {31'h0, overflow_out});
    for (int i = 0; i < 20; i++)
      push(16'h2000 + 16'(i));
    chk("recyc words", 32'd20, 32'(srbw_host_mem_i.n_wr - w0));
    chk("wrap addr", 32'h6, 32'(srbw_host_mem_i.last_addr));
    chk("newest", 32'h2013, 32'(srbw_host_mem_i.mem[3]));
    chk("no overflow", 32'h0, {31'h0, overflow_out});
  endtask : t_recyc
  task automatic t_scan;
    bus(1'b1, REG_CTRL, 32'h2);
    bus(1'b1, REG_SETUP, 32'h0001_0018);
    @(posedge ref_clk_in);
    chk("conv enable", 32'h1, {31'h0, conv_enable_out});
    f0 = n_start;
    bus(1'b1, REG_CTRL, 32'h4);
    repeat (3) @(posedge ref_clk_in);
    chk("sw scan", 32'h1, 32'(n_start - f0));
    bus(1'b1, REG_SETUP, 32'h0001_0038);
    @(posedge ref_clk_in);
    scan_pacing_pulse_in <= 1'b1;
    @(posedge ref_clk_in);
    scan_pacing_pulse_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    chk("ext scan", 32'h2, 32'(n_start - f0));
    // go together with single scan: running, yet nothing reaches the host
    bus(1'b1, REG_CTRL, 32'h9);
    w0 = srbw_host_mem_i.n_wr;
    push(16'h0bad);
    chk("fifo keep", 32'h1, {31'h0, fifo_keep_out});
    chk("no host wr", 32'h0, 32'(srbw_host_mem_i.n_wr - w0));
    bus(1'b0, REG_STATUS, '0);
    chk("scan index", 32'h0, {31'h0, q[8]});
  endtask : t_scan

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    t_regs();
    t_single();
    t_res();
    t_circ();
    t_recyc();
    t_scan();
    results();
  end
endmodule : sample_ring_buffer_writer_test
